// [hdl/bmeaw_pkg.sv]
// Shared constants and types for the boot mode entry and access window block.
package bmeaw_pkg;

  // Widths of the sector setting value and of the code flash byte address.
  localparam int SV_W = 10;
  localparam int FADDR_W = 22;

  // Register offsets, byte addresses on the APB.
  localparam logic [7:0] OFS_WIN_START = 8'h00;
  localparam logic [7:0] OFS_WIN_END = 8'h04;
  localparam logic [7:0] OFS_LOCK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_BAUD = 8'h10;

  // Reset values.
  localparam logic [SV_W-1:0] WIN_START_RST = 10'h000;
  localparam logic [SV_W-1:0] WIN_END_RST = 10'h000;
  localparam logic LOCK_RST = 1'b1;

  // Field positions.
  localparam int LOCK_BIT = 0;
  localparam int BAUD_DIV_W = 16;
  localparam int BAUD_COMMIT_BIT = 31;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_SERIAL_BIT = 4;
  localparam int ST_DEBUG_BIT = 5;
  localparam int ST_SECHALT_BIT = 6;
  localparam int ST_UART_BIT = 7;
  localparam int ST_USB_BIT = 8;
  localparam int ST_HSPEED_BIT = 9;

  // Mode select pin level that asks for serial programming mode.
  localparam logic MODE_PIN_SERIAL = 1'b0;

  // Series codes.
  localparam int SERIES_LARGE = 0;
  localparam int SERIES_MIDDLE = 1;
  localparam int SERIES_SMALL = 2;

  // Large series layout: this many 8 KB sectors at the bottom, 32 KB sectors above them.
  localparam int LARGE_SMALL_SECTORS = 8;

  // Clock rate and the boot-time UART rate.
  localparam int CLK_HZ = 10_000_000;
  localparam int BOOT_BAUD_BPS = 9600;
  localparam logic [BAUD_DIV_W-1:0] BOOT_BAUD_DIV = BAUD_DIV_W'(CLK_HZ / BOOT_BAUD_BPS);

  typedef enum logic [3:0] {
    BMEAW_SAMPLE,
    BMEAW_SEC_HALT,
    BMEAW_COMM_SETUP,
    BMEAW_UART,
    BMEAW_USB,
    BMEAW_ERASE_USER,
    BMEAW_ERASE_CFG,
    BMEAW_HALT
  } bmeaw_state_e;

endpackage

// [hdl/bmeaw_sector_map.sv]
// Maps a code flash byte address to its sector setting value for one series.
`timescale 1ns/1ps
`default_nettype none
module bmeaw_sector_map
  import bmeaw_pkg::*;
#(
  parameter int SERIES = SERIES_LARGE
) (
  input wire logic [FADDR_W-1:0] addr,
  output logic [SV_W-1:0] setting
);

  // Setting value of the sector holding the address.
  function automatic logic [SV_W-1:0] sector_value(input logic [FADDR_W-1:0] a);
    logic [SV_W-1:0] v;
    v = '0;
    if (SERIES == SERIES_LARGE) begin
      // Eight 8 KB sectors count by one, each 32 KB sector after them by four.
      if (a[FADDR_W-1:16] == '0) begin
        v = SV_W'(a[15:13]);
      end else begin
        v = SV_W'({a[FADDR_W-1:15], 2'b00});
      end
    end else if (SERIES == SERIES_MIDDLE) begin
      // 2 KB sectors; value is the base in 1 KB units, so it steps by two.
      v = {a[19:11], 1'b0};
    end else begin
      // 1 KB sectors; value is the sector index, last one at 3FFh.
      v = a[19:10];
    end
    return v;
  endfunction

  assign setting = sector_value(addr);

endmodule
`default_nettype wire

// [hdl/bmeaw_top.sv]
// Boot mode entry sequencer with code flash access window and APB registers.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bmeaw_top
  import bmeaw_pkg::*;
#(
  parameter int SERIES = SERIES_LARGE,
  parameter bit USB_PRESENT = 1'b1,
  parameter bit USB_CLK_SELECTABLE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_select_pin,
  input wire logic security_protection_unit,
  input wire logic vcc_above_2v4,
  input wire logic rxd,
  input wire logic usb_configured,
  output logic erase_req,
  output logic erase_config_area,
  input wire logic erase_done,
  input wire logic flash_req_valid,
  input wire logic [FADDR_W-1:0] flash_req_addr,
  output logic flash_req_grant,
  output logic flash_req_refuse,
  output logic serial_prog_mode,
  output logic debug_mode,
  output logic halted,
  output logic comm_uart,
  output logic comm_usb,
  output logic uart_bit_tick,
  output logic high_speed_mode,
  output logic usb_clock_source_select,
  output logic main_osc_needed
);

  // Parameters that the logic cannot serve are refused at elaboration.
  // Caught here rather than left to fall silently into the small-series map.
  if (SERIES < SERIES_LARGE || SERIES > SERIES_SMALL) begin : g_bad_series
    $error("bmeaw_top: SERIES must be 0, 1 or 2");
  end
  if (USB_CLK_SELECTABLE && !USB_PRESENT) begin : g_bad_usb
    $error("bmeaw_top: USB clock select needs USB present");
  end

  // Sequencer state, captured mode flags, window registers and baud divider.
  bmeaw_state_e state_r;
  bmeaw_state_e state_nxt;
  logic serial_r;
  logic debug_r;
  logic sechalt_r;
  logic rxd_prev_r;
  logic rxd_fall;
  logic [SV_W-1:0] win_start_r;
  logic [SV_W-1:0] win_end_r;
  logic lock_r;
  logic [BAUD_DIV_W-1:0] baud_div_r;
  logic [BAUD_DIV_W-1:0] baud_cnt_r;
  logic [SV_W-1:0] req_setting;
  logic in_window;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic [31:0] status_word;

  // Mode decision and the erase/halt sequence.
  // Security is tested first so that a protected part never starts an erase.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BMEAW_SAMPLE: begin
        if (security_protection_unit) begin
          state_nxt = BMEAW_SEC_HALT;
        end else if (mode_select_pin == MODE_PIN_SERIAL) begin
          state_nxt = BMEAW_COMM_SETUP;
        end else begin
          state_nxt = BMEAW_ERASE_USER;
        end
      end
      BMEAW_COMM_SETUP: begin
        // USB wins when both cues land in one cycle, as USB is checked first.
        if (USB_PRESENT && usb_configured) begin
          state_nxt = BMEAW_USB;
        end else if (rxd_fall) begin
          state_nxt = BMEAW_UART;
        end
      end
      BMEAW_ERASE_USER: begin
        if (erase_done) begin
          state_nxt = BMEAW_ERASE_CFG;
        end
      end
      BMEAW_ERASE_CFG: begin
        if (erase_done) begin
          state_nxt = BMEAW_HALT;
        end
      end
      BMEAW_SEC_HALT, BMEAW_HALT, BMEAW_UART, BMEAW_USB: begin
        state_nxt = state_r;
      end
      default: begin
        state_nxt = BMEAW_HALT;
      end
    endcase
  end

  // State register; reset always restarts at the pin sampling step.
  // A reset in mid-run therefore reads the pins afresh, as a power-on reset would.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= BMEAW_SAMPLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The pin and the security level are caught once, in the first cycle after reset.
  // Later pin changes are ignored, so a bouncing pin cannot switch modes after entry.
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_r <= 1'b0;
      debug_r <= 1'b0;
      sechalt_r <= 1'b0;
    end else if (state_r == BMEAW_SAMPLE) begin
      sechalt_r <= security_protection_unit;
      serial_r <= !security_protection_unit && (mode_select_pin == MODE_PIN_SERIAL);
      debug_r <= !security_protection_unit && (mode_select_pin != MODE_PIN_SERIAL);
    end
  end

  // Receive line edge detector; idle line is high.
  // Resetting the history to the idle level keeps reset itself from looking like an edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_prev_r <= 1'b1;
    end else begin
      rxd_prev_r <= rxd;
    end
  end
  assign rxd_fall = rxd_prev_r && !rxd;

  // Erase requests hold until the flash answers with erase_done.
  assign erase_req = (state_r == BMEAW_ERASE_USER) || (state_r == BMEAW_ERASE_CFG);
  assign erase_config_area = (state_r == BMEAW_ERASE_CFG);

  // Mode and link indications.
  assign serial_prog_mode = serial_r;
  assign debug_mode = debug_r;
  assign halted = (state_r == BMEAW_HALT) || (state_r == BMEAW_SEC_HALT);
  assign comm_uart = (state_r == BMEAW_UART);
  assign comm_usb = (state_r == BMEAW_USB);

  // Large parts always run fast; smaller ones fall back below 2.4 V.
  assign high_speed_mode = (SERIES == SERIES_LARGE) ? 1'b1 : vcc_above_2v4;

  // With a selectable source the USB clock comes from the internal oscillator.
  assign usb_clock_source_select = USB_CLK_SELECTABLE;
  assign main_osc_needed = USB_PRESENT && !USB_CLK_SELECTABLE && comm_usb;

  // Window check on each flash request.
  // The series parameter picks how addresses fold into setting values.
  bmeaw_sector_map #(
    .SERIES(SERIES)
  ) u_map (
    .addr(flash_req_addr),
    .setting(req_setting)
  );
  // End holds last sector plus one, so the upper bound is exclusive.
  assign in_window = (req_setting >= win_start_r) && (req_setting < win_end_r);

  // Grant or refusal is answered one cycle after the request, as a pulse.
  // The register costs a cycle but keeps the answer clean of the address decode's settling.
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_req_grant <= 1'b0;
      flash_req_refuse <= 1'b0;
    end else begin
      flash_req_grant <= flash_req_valid && in_window;
      flash_req_refuse <= flash_req_valid && !in_window;
    end
  end

  // APB decode: zero wait states, unmapped offsets answer with an error.
  // With no waits a master may run transfers back to back without polling.
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == OFS_WIN_START) || (paddr == OFS_WIN_END) || (paddr == OFS_LOCK)
    || (paddr == OFS_STATUS) || (paddr == OFS_BAUD);
  assign pslverr = psel && penable && !addr_ok;

  // Window fields only change while the lock bit still reads one.
  always_ff @(posedge clk) begin
    if (rst) begin
      win_start_r <= WIN_START_RST;
      win_end_r <= WIN_END_RST;
    end else if (apb_wr && lock_r) begin
      if (paddr == OFS_WIN_START) begin
        win_start_r <= pwdata[SV_W-1:0];
      end
      if (paddr == OFS_WIN_END) begin
        win_end_r <= pwdata[SV_W-1:0];
      end
    end
  end

  // The lock bit can only be cleared, so a frozen window stays frozen until reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_r <= LOCK_RST;
    end else if (apb_wr && paddr == OFS_LOCK && !pwdata[LOCK_BIT]) begin
      lock_r <= 1'b0;
    end
  end

  // Bit rate divisor: boot rate until software reports the baud command done.
  // A zero divisor would wrap to one bit tick per 65536 cycles, so such a write is ignored.
  always_ff @(posedge clk) begin
    if (rst) begin
      baud_div_r <= BOOT_BAUD_DIV;
    end else if (apb_wr && paddr == OFS_BAUD && pwdata[BAUD_COMMIT_BIT]
                 && pwdata[BAUD_DIV_W-1:0] != '0) begin
      baud_div_r <= pwdata[BAUD_DIV_W-1:0];
    end
  end

  // Bit tick divider runs only while the UART link is chosen.
  // Clearing the count before entry makes the first bit time a full one.
  always_ff @(posedge clk) begin
    if (rst) begin
      baud_cnt_r <= '0;
      uart_bit_tick <= 1'b0;
    end else if (state_r != BMEAW_UART) begin
      baud_cnt_r <= '0;
      uart_bit_tick <= 1'b0;
    end else if (baud_cnt_r >= baud_div_r - 1'b1) begin
      baud_cnt_r <= '0;
      uart_bit_tick <= 1'b1;
    end else begin
      baud_cnt_r <= baud_cnt_r + 1'b1;
      uart_bit_tick <= 1'b0;
    end
  end

  // Status word shows the sequencer's own state.
  // Software can tell from it which path the part took out of reset.
  always_comb begin
    status_word = '0;
    status_word[ST_STATE_LSB +: 4] = state_r;
    status_word[ST_SERIAL_BIT] = serial_r;
    status_word[ST_DEBUG_BIT] = debug_r;
    status_word[ST_SECHALT_BIT] = sechalt_r;
    status_word[ST_UART_BIT] = comm_uart;
    status_word[ST_USB_BIT] = comm_usb;
    status_word[ST_HSPEED_BIT] = high_speed_mode;
  end

  // Read data is registered at the setup phase so it is stable in the access phase.
  // Unmapped offsets read as zero beside the error response.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFS_WIN_START: prdata <= 32'(win_start_r);
        OFS_WIN_END: prdata <= 32'(win_end_r);
        OFS_LOCK: prdata <= 32'(lock_r);
        OFS_STATUS: prdata <= status_word;
        OFS_BAUD: prdata <= 32'(baud_div_r);
        default: prdata <= '0;
      endcase
    end else if (!apb_rd) begin
      prdata <= '0;
    end
  end

endmodule
`default_nettype wire

// [testbench/bmeaw_prog_model.sv]
// Partner model: serial programmer low pulse, USB enumeration and flash erase completion.
`timescale 1ns/1ps
`default_nettype none
module bmeaw_prog_model
  import bmeaw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic send,
  input wire logic usb_go,
  input wire logic erase_req,
  input wire logic [7:0] dly,
  output logic rxd,
  output logic usb_configured,
  output logic erase_done
);
  logic [13:0] low_r;
  logic [7:0] cnt_r;
  // A zero byte at the boot rate holds the line low for nine bit times, then idles high.
  always_ff @(posedge clk) begin
    if (rst) begin
      low_r <= 14'h0000;
    end else if (send) begin
      low_r <= 14'(9 * BOOT_BAUD_DIV);
    end else if (low_r != 14'h0000) begin
      low_r <= low_r - 14'h0001;
    end
  end
  assign rxd = (low_r == 14'h0000);
  // Enumeration completes one cycle after the bench asks for it.
  always_ff @(posedge clk) begin
    usb_configured <= usb_go && !rst;
  end
  // Each erase step ends after a set wait, so both prompt and slow flash are exercised.
  always_ff @(posedge clk) begin
    erase_done <= !rst && erase_req && !erase_done && cnt_r == dly;
    cnt_r <= (!rst && erase_req && !erase_done && cnt_r != dly) ? cnt_r + 8'h01 : 8'h00;
  end
endmodule
`default_nettype wire

// [testbench/bmeaw_props.sv]
// Concurrent checks on the boot mode entry and access window ports.
`timescale 1ns/1ps
`default_nettype none
module bmeaw_props
  import bmeaw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_select_pin,
  input wire logic security_protection_unit,
  input wire logic usb_configured,
  input wire logic erase_req,
  input wire logic erase_config_area,
  input wire logic erase_done,
  input wire logic flash_req_valid,
  input wire logic flash_req_grant,
  input wire logic flash_req_refuse,
  input wire logic serial_prog_mode,
  input wire logic debug_mode,
  input wire logic halted,
  input wire logic comm_uart,
  input wire logic comm_usb
);
  // One clock domain; nothing is judged while reset is held.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_entry; $fell(rst) && !security_protection_unit; endsequence
  sequence s_user_done; erase_req && !erase_config_area && erase_done; endsequence
  sequence s_cfg_done; erase_req && erase_config_area && erase_done; endsequence
  property p_answer; flash_req_valid |=> flash_req_grant ^ flash_req_refuse; endproperty
  property p_cause; flash_req_grant || flash_req_refuse |-> $past(flash_req_valid); endproperty
  property p_sec; $fell(rst) && security_protection_unit |=> halted && !serial_prog_mode && !debug_mode && !erase_req;
  endproperty
  property p_ser; s_entry ##0 mode_select_pin == MODE_PIN_SERIAL |=> serial_prog_mode && !debug_mode && !halted;
  endproperty
  property p_dbg; s_entry ##0 mode_select_pin != MODE_PIN_SERIAL |=> debug_mode && erase_req && !erase_config_area;
  endproperty
  property p_usr; s_user_done |=> erase_req && erase_config_area; endproperty
  property p_cfg; s_cfg_done |=> (halted && !erase_req) [*3]; endproperty
  property p_hold; halted |=> halted && !comm_uart && !comm_usb; endproperty
  property p_usb; serial_prog_mode && !comm_uart && !comm_usb && usb_configured |=> comm_usb && !comm_uart; endproperty
  a_answer: assert property (p_answer) else $error("request answer missing");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_sec: assert property (p_sec) else $error("protected part did not halt");
  a_ser: assert property (p_ser) else $error("serial entry wrong");
  a_dbg: assert property (p_dbg) else $error("debug entry wrong");
  a_usr: assert property (p_usr) else $error("config erase not started");
  a_cfg: assert property (p_cfg) else $error("no halt after erase");
  a_hold: assert property (p_hold) else $error("halt left");
  a_usb: assert property (p_usb) else $error("usb not chosen");
endmodule
bind bmeaw_top bmeaw_props bmeaw_props_i (.clk, .rst, .mode_select_pin, .security_protection_unit, .usb_configured,
  .erase_req, .erase_config_area, .erase_done, .flash_req_valid, .flash_req_grant, .flash_req_refuse,
  .serial_prog_mode, .debug_mode, .halted, .comm_uart, .comm_usb);
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for boot mode entry, access window and boot baud rate.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import bmeaw_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, mode_select_pin, security_protection_unit;
  logic vcc_above_2v4, rxd, usb_configured, erase_req, erase_config_area, erase_done, flash_req_valid;
  logic flash_req_grant, flash_req_refuse, serial_prog_mode, debug_mode, halted, comm_uart, comm_usb;
  logic uart_bit_tick, high_speed_mode, usb_clock_source_select, main_osc_needed, send, usb_go, e;
  logic [7:0] paddr, dly;
  logic [31:0] pwdata, prdata, q;
  logic [21:0] flash_req_addr;
  logic [15:0] r;
  int n_mismatch, n_compared, cyc, i, n;
  logic [7:0] ofs_t [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  logic [31:0] rst_t [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0001, {16'h0000, BOOT_BAUD_DIV}};
  logic mid_grant, mid_refuse, mid_speed, mid_usbsel, mid_osc, mid_usb;
  logic [21:0] corner_t [9] = '{22'h00_E000, 22'h00_C000, 22'h01_FFFF, 22'h02_8000, 22'h02_7FFF,
    22'h00_1800, 22'h00_2000, 22'h00_4800, 22'h00_5000};
  bmeaw_top bmeaw_top_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mode_select_pin, .security_protection_unit, .vcc_above_2v4, .rxd, .usb_configured, .erase_req,
    .erase_config_area, .erase_done, .flash_req_valid, .flash_req_addr, .flash_req_grant, .flash_req_refuse,
    .serial_prog_mode, .debug_mode, .halted, .comm_uart, .comm_usb, .uart_bit_tick, .high_speed_mode,
    .usb_clock_source_select, .main_osc_needed);
  bmeaw_prog_model bmeaw_prog_model_i (.clk, .rst, .send, .usb_go, .erase_req, .dly, .rxd, .usb_configured,
    .erase_done);
  // A middle-series part with a selectable USB clock shares every input with the large one.
  bmeaw_top #(
    .SERIES(SERIES_MIDDLE),
    .USB_PRESENT(1'b1),
    .USB_CLK_SELECTABLE(1'b1)
  ) bmeaw_top_mid_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(),
    .mode_select_pin, .security_protection_unit, .vcc_above_2v4, .rxd, .usb_configured, .erase_req(),
    .erase_config_area(), .erase_done, .flash_req_valid, .flash_req_addr, .flash_req_grant(mid_grant),
    .flash_req_refuse(mid_refuse), .serial_prog_mode(), .debug_mode(), .halted(), .comm_uart(),
    .comm_usb(mid_usb), .uart_bit_tick(), .high_speed_mode(mid_speed), .usb_clock_source_select(mid_usbsel),
    .main_osc_needed(mid_osc));
  // Sixteen-bit LFSR keeps the random traffic repeatable.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Window holds 007 up to 013. Large parts count 8 KB units, 32 KB sectors stepping by four;
  // middle parts give the 2 KB sector base in 1 KB units, so their values are even.
  function automatic logic exp_ok(input logic [21:0] a, input logic mid);
    logic [9:0] v;
    if (mid) v = a[19:10] & 10'h3FE;
    else v = (a < 22'h01_0000) ? 10'(a[15:13]) : {1'b0, a[21:15], 2'b00};
    return v >= 10'h007 && v < 10'h014;
  endfunction
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Pins are held steady through release so the first edge out of reset samples them.
  task do_reset(input logic m, input logic s);
    @(posedge clk);
    rst <= 1'b1;
    mode_select_pin <= m;
    security_protection_unit <= s;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // APB transfer; the answer is taken at the rising edge that sees pready high, before that edge's updates land.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task flash(input logic [21:0] a);
    logic gl, gm;
    gl = exp_ok(a, 1'b0);
    gm = exp_ok(a, 1'b1);
    @(posedge clk);
    flash_req_valid <= 1'b1;
    flash_req_addr <= a;
    vcc_above_2v4 <= r[0];
    @(posedge clk);
    flash_req_valid <= 1'b0;
    @(negedge clk);
    chk("answer", {30'h0, gl, !gl}, {30'h0, flash_req_grant, flash_req_refuse});
    chk("mid_answer", {30'h0, gm, !gm}, {30'h0, mid_grant, mid_refuse});
    chk("speed", 32'h0000_0001, {31'h0, high_speed_mode});
    chk("mid_speed", {31'h0, r[0]}, {31'h0, mid_speed});
  endtask
  task tick_gap;
    for (n = 0; n < 3000 && uart_bit_tick !== 1'b1; n++) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cuts a hang short; the whole plan needs about 1600 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      final_report;
    end
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, flash_req_valid, flash_req_addr, send, usb_go} = '0;
    {rst, vcc_above_2v4, mode_select_pin, security_protection_unit, dly, r} = {1'b1, 11'h000, 16'hE181};
    // Debug entry twice: once with a slow flash, once with a flash that answers at once.
    for (n = 0; n < 2; n++) begin
      dly <= (n == 0) ? 8'h28 : 8'h00;
      do_reset(1'b1, 1'b0);
      for (i = 0; i < 300 && halted !== 1'b1; i++) @(negedge clk);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("debug_status", 32'h0000_0227, q);
    end
    do_reset(1'b0, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("sec_status", 32'h0000_0241, q);
    do_reset(1'b0, 1'b0);
    usb_go <= 1'b1;
    repeat (4) @(negedge clk);
    chk("usb", 32'h0000_0005, {29'h0, comm_usb, usb_clock_source_select, main_osc_needed});
    chk("mid_usb", 32'h0000_0006, {29'h0, mid_usb, mid_usbsel, mid_osc});
    for (i = 0; i < 4; i++) begin
      apb(1'b0, ofs_t[i], 32'h0000_0000);
      chk("reset_value", rst_t[i], q);
    end
    apb(1'b1, OFS_WIN_START, 32'h0000_0007);
    apb(1'b1, OFS_WIN_END, 32'h0000_0014);
    for (i = 0; i < 9; i++) flash(corner_t[i]);
    for (i = 0; i < 40; i++) begin
      r = lfsr(r);
      flash({4'h0, r[1:0], r});
    end
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {q[30:0], e});
    apb(1'b1, OFS_LOCK, 32'h0000_0000);
    apb(1'b1, OFS_WIN_START, 32'h0000_0000);
    apb(1'b1, OFS_LOCK, 32'h0000_0001);
    apb(1'b0, OFS_WIN_START, 32'h0000_0000);
    chk("locked_start", 32'h0000_0007, q);
    apb(1'b0, OFS_LOCK, 32'h0000_0000);
    chk("lock_sticky", 32'h0000_0000, q);
    usb_go <= 1'b0;
    do_reset(1'b0, 1'b0);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    for (i = 0; i < 200 && comm_uart !== 1'b1; i++) @(negedge clk);
    tick_gap;
    chk("first_tick", 32'h0000_0001, {31'h0, n >= BOOT_BAUD_DIV - 1 && n <= BOOT_BAUD_DIV + 1});
    apb(1'b1, OFS_BAUD, 32'h8000_0064);
    tick_gap;
    @(negedge clk);
    tick_gap;
    chk("new_rate", 32'h0000_0063, 32'(n));
    final_report;
  end
endmodule
`default_nettype wire
